// file: design/adcs0_pkg.sv
// Constants shared by the step configuration store of sequencer zero.
// Assumes a 32-bit APB register bus with byte addresses.
package adcs0_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] OFF_INPUT_SEL = 12'h040;
   localparam logic [11:0] OFF_STEP_CTRL = 12'h044;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h048;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h04C;
   localparam logic [11:0] OFF_RUN_CTRL = 12'h050;
   localparam logic [11:0] OFF_RUN_STATUS = 12'h054;
   localparam int unsigned STEPS = 8;
   localparam int unsigned SEL_W = 2;
   localparam int unsigned SEL_STRIDE = 4;
   localparam int unsigned CTRL_STRIDE = 4;
   // Bit positions inside one 4-bit step control group.
   localparam int unsigned CTRL_DIFF = 0;
   localparam int unsigned CTRL_LAST = 1;
   localparam int unsigned CTRL_IRQ = 2;
   localparam int unsigned CTRL_TEMP = 3;
   // Interrupt status and mask layout.
   localparam int unsigned IRQ_RAW = 0;
   localparam int unsigned IRQ_DONE = 1;
   localparam int unsigned IRQ_W = 2;
   localparam int unsigned RUN_START = 0;
   localparam int unsigned STAT_BUSY = 0;
   localparam int unsigned STAT_STEP_LSB = 4;
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   localparam logic [31:0] SEL_FIELD_MASK = 32'h33333333;
   localparam logic [2:0] LAST_STEP = 3'h7;
   typedef enum logic [0:0] {ADCS0_IDLE, ADCS0_CONVERT} adcs0_state_e;
endpackage

// file: design/adcs0_step_pick.sv
// Picks the configuration of one step out of the two configuration words.
// Assumes the caller provides the step index on the same clock.
`timescale 1ns/100ps
`default_nettype none
module adcs0_step_pick (
   input wire logic [31:0] input_sel_word,
   input wire logic [31:0] step_ctrl_word,
   input wire logic [2:0] step,
   output logic [1:0] step_input_sel,
   output logic step_temp_select,
   output logic step_irq_enable,
   output logic step_last_marker,
   output logic step_differential
);
   logic [3:0] group;

   // Each step owns one nibble of both words; the select uses the low two bits.
   always_comb begin
      group = step_ctrl_word[step * adcs0_pkg::CTRL_STRIDE +: adcs0_pkg::CTRL_STRIDE];
      step_input_sel = input_sel_word[step * adcs0_pkg::SEL_STRIDE +: adcs0_pkg::SEL_W];
      step_temp_select = group[adcs0_pkg::CTRL_TEMP];
      step_irq_enable = group[adcs0_pkg::CTRL_IRQ];
      step_last_marker = group[adcs0_pkg::CTRL_LAST];
      step_differential = group[adcs0_pkg::CTRL_DIFF];
   end
endmodule
`default_nettype wire

// file: design/adcs0_seq.sv
// Step configuration store and step walker of sample sequencer zero.
// Assumes an APB master on pclk and a converter front end on the same clock
// that answers each request with a one-cycle done pulse.
// The clock enable freezes every register, the APB answer included, while it is low.
// Converter requests are held as levels; the front end must not answer one request twice.
// Limitation: a start written while a sequence runs is dropped, not queued.
//
// Summary of operation
// - Eight 2-bit input-select fields sit at bits 1:0 for the first step up to bits 29:28 for the eighth.
// - A step's input-select value is the number of the analog channel it converts.
// - The 2-bit gaps above each select field are read-only, read here as zero, and software leaves them alone.
// - The step control word is 32-bit, read/write, resets to zero, one nibble per step: temp, irq, end, diff.
// - A step with temperature select set converts the internal sensor, otherwise its selected pin.
// - A step with interrupt enable set raises the raw sequencer flag when its conversion ends.
// - The sequence stops after the step carrying the end marker; later steps are never requested.
// - A differential step samples pair 2i and 2i+1; the temperature sensor has no differential mode.
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`default_nettype none
module adcs0_seq (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_done,
   output logic conv_req,
   output logic conv_temp_select,
   output logic conv_differential,
   output logic [1:0] conv_input_sel,
   output logic seq_busy,
   output logic irq
);
   logic [31:0] input_sel_reg;
   logic [31:0] step_ctrl_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_mask_reg;
   logic [2:0] step_reg;
   adcs0_pkg::adcs0_state_e state_reg;
   logic [1:0] cur_input_sel;
   logic cur_temp;
   logic cur_irq_en;
   logic cur_last;
   logic cur_diff;
   logic access;
   logic wr_commit;
   logic mapped;
   logic start_req;
   logic step_end;
   logic step_is_last;
   logic [1:0] irq_set;
   logic [31:0] read_word;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode.

   // The slave inserts one wait state so that read data and pready come from flops.
   assign access = psel && penable && !pready;
   assign wr_commit = psel && penable && pready && pwrite;
   assign start_req = wr_commit && paddr == adcs0_pkg::OFF_RUN_CTRL && pwdata[adcs0_pkg::RUN_START];

   // Unmapped addresses answer with pslverr and read as zero; writes to them change nothing.
   // Read mux; gap bits of the select word come back as zero.
   always_comb begin
      mapped = 1'b1;
      read_word = adcs0_pkg::RESET_WORD;
      case (paddr)
         adcs0_pkg::OFF_INPUT_SEL: read_word = input_sel_reg;
         adcs0_pkg::OFF_STEP_CTRL: read_word = step_ctrl_reg;
         adcs0_pkg::OFF_IRQ_STATUS: read_word[adcs0_pkg::IRQ_W-1:0] = irq_status_reg;
         adcs0_pkg::OFF_IRQ_MASK: read_word[adcs0_pkg::IRQ_W-1:0] = irq_mask_reg;
         adcs0_pkg::OFF_RUN_CTRL: read_word = adcs0_pkg::RESET_WORD;
         adcs0_pkg::OFF_RUN_STATUS: begin
            read_word[adcs0_pkg::STAT_BUSY] = seq_busy;
            read_word[adcs0_pkg::STAT_STEP_LSB +: 3] = step_reg;
         end
         default: mapped = 1'b0;
      endcase
   end

   // Answer: pready, read data and error all settle one cycle into the access phase.
   // Read data is loaded on reads only, so it holds until the next read transfer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= adcs0_pkg::RESET_WORD;
      end else if (clk_en) begin
         pready <= access;
         pslverr <= access && !mapped;
         if (access && !pwrite) begin
            prdata <= read_word;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration words.

   // Only the select fields are stored, so the gaps cannot be changed by a write.
   // A write commits only at the edge where pready is high, never in the wait state.
   // The control word keeps all 32 bits, since every bit is a step option.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_sel_reg <= adcs0_pkg::RESET_WORD;
         step_ctrl_reg <= adcs0_pkg::RESET_WORD;
      end else if (clk_en && wr_commit) begin
         if (paddr == adcs0_pkg::OFF_INPUT_SEL) begin
            input_sel_reg <= pwdata & adcs0_pkg::SEL_FIELD_MASK;
         end
         if (paddr == adcs0_pkg::OFF_STEP_CTRL) begin
            step_ctrl_reg <= pwdata;
         end
      end
   end

   // Fields of the current step come from the live words, so a rewrite mid-sequence acts at once.
   adcs0_step_pick u_pick (
      .input_sel_word(input_sel_reg),
      .step_ctrl_word(step_ctrl_reg),
      .step(step_reg),
      .step_input_sel(cur_input_sel),
      .step_temp_select(cur_temp),
      .step_irq_enable(cur_irq_en),
      .step_last_marker(cur_last),
      .step_differential(cur_diff)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Step walker.

   // A step ends when the front end reports its conversion done.
   assign step_end = state_reg == adcs0_pkg::ADCS0_CONVERT && conv_done;

   // The last step carries the end marker, or is the eighth when software set none.
   // One signal feeds both the walker and the done flag, so they never disagree on the end.
   assign step_is_last = cur_last || step_reg == adcs0_pkg::LAST_STEP;

   // Start is ignored while a sequence runs; software cannot restart mid-sequence.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= adcs0_pkg::ADCS0_IDLE;
         step_reg <= 3'h0;
      end else if (clk_en) begin
         case (state_reg)
            adcs0_pkg::ADCS0_IDLE: begin
               if (start_req) begin
                  state_reg <= adcs0_pkg::ADCS0_CONVERT;
                  step_reg <= 3'h0;
               end
            end
            adcs0_pkg::ADCS0_CONVERT: begin
               if (step_end) begin
                  if (step_is_last) begin
                     state_reg <= adcs0_pkg::ADCS0_IDLE;
                  end else begin
                     step_reg <= step_reg + 3'h1;
                  end
               end
            end
            default: state_reg <= adcs0_pkg::ADCS0_IDLE;
         endcase
      end
   end

   // Request outputs follow the current step; they update one cycle after the step changes.
   // Trade-off: the one-cycle gap between steps keeps conv_req a plain flop output.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_req <= 1'b0;
         conv_temp_select <= 1'b0;
         conv_differential <= 1'b0;
         conv_input_sel <= 2'h0;
         seq_busy <= 1'b0;
      end else if (clk_en) begin
         seq_busy <= state_reg == adcs0_pkg::ADCS0_CONVERT;
         conv_req <= state_reg == adcs0_pkg::ADCS0_CONVERT && !step_end;
         conv_temp_select <= cur_temp;
         conv_differential <= cur_diff && !cur_temp;
         conv_input_sel <= cur_input_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts.

   // Several steps may raise the raw flag; a set in the same cycle as a clear wins.
   // The done flag marks the end of every sequence, whether or not a step raised the raw flag.
   always_comb begin
      irq_set = 2'h0;
      irq_set[adcs0_pkg::IRQ_RAW] = step_end && cur_irq_en;
      irq_set[adcs0_pkg::IRQ_DONE] = step_end && step_is_last;
   end

   // Status is write-one-to-clear; the mask only gates the output, never the status bits.
   // The irq flop costs a cycle of delay but keeps the output free of glitches.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= 2'h0;
         irq_mask_reg <= 2'h0;
         irq <= 1'b0;
      end else if (clk_en) begin
         if (wr_commit && paddr == adcs0_pkg::OFF_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~pwdata[adcs0_pkg::IRQ_W-1:0]) | irq_set;
         end else begin
            irq_status_reg <= irq_status_reg | irq_set;
         end
         if (wr_commit && paddr == adcs0_pkg::OFF_IRQ_MASK) begin
            irq_mask_reg <= pwdata[adcs0_pkg::IRQ_W-1:0];
         end
         irq <= |(irq_status_reg & irq_mask_reg); // One cycle behind status, from a flop.
      end
   end
endmodule
`default_nettype wire

// file: test/adcs0_front_model.sv
// Behavioural converter front end for the sequencer zero step walker.
// Assumes one pclk domain; lat sets how many request cycles pass before done.
`timescale 1ns/100ps
`default_nettype none
module adcs0_front_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic conv_req,
   input wire logic conv_temp_select,
   input wire logic conv_differential,
   input wire logic [1:0] conv_input_sel,
   input wire logic [3:0] lat,
   output logic conv_done
);
   logic [3:0] seen[$];
   logic [3:0] cnt;
   // Done is never given twice for one request: the cycle after it is always quiet.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_done <= 1'b0;
         cnt <= 4'h0;
      end else if (conv_done) begin
         conv_done <= 1'b0;
      end else if (conv_req && cnt == lat) begin
         conv_done <= 1'b1;
         cnt <= 4'h0;
         seen.push_back({conv_temp_select, conv_differential, conv_input_sel});
      end else if (conv_req) begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// file: test/adcs0_seq_properties.sv
// Concurrent checks on the APB and converter ports of the sequencer zero store.
// Assumes it is bound to adcs0_seq with clk_en held high.
`timescale 1ns/100ps
`default_nettype none
module adcs0_seq_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic conv_done,
   input wire logic conv_req,
   input wire logic conv_temp_select,
   input wire logic conv_differential,
   input wire logic seq_busy,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc;
      psel && penable && pready;
   endsequence
   sequence s_start;
      s_acc ##0 (pwrite && paddr == 12'h050 && pwdata[0] && !seq_busy);
   endsequence
   sequence s_done;
      conv_req && conv_done;
   endsequence
   property p_gap;
      s_acc ##0 (!pwrite && paddr == 12'h040) |-> (prdata & 32'hCCCCCCCC) == 32'h00000000;
   endproperty
   property p_wait;
      psel && penable && !pready |=> pready;
   endproperty
   property p_err;
      pslverr && !pwrite |-> pready && prdata == 32'h00000000;
   endproperty
   property p_start;
      s_start |-> ##2 (conv_req && seq_busy);
   endproperty
   property p_fall;
      s_done |=> !conv_req;
   endproperty
   property p_hold;
      conv_req && !conv_done |=> conv_req && seq_busy;
   endproperty
   property p_temp;
      conv_req && conv_temp_select |-> !conv_differential;
   endproperty
   property p_rst;
      $rose(presetn) |-> !irq && !conv_req && !seq_busy;
   endproperty
   a_gap: assert property (p_gap) else $error("select gap bits read non-zero");
   a_wait: assert property (p_wait) else $error("pready late");
   a_err: assert property (p_err) else $error("error read carried data");
   a_start: assert property (p_start) else $error("start did not request step");
   a_fall: assert property (p_fall) else $error("request held past done");
   a_hold: assert property (p_hold) else $error("request dropped early");
   a_temp: assert property (p_temp) else $error("differential on sensor");
   a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule
bind adcs0_seq adcs0_seq_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .conv_done, .conv_req, .conv_temp_select, .conv_differential, .seq_busy, .irq);
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the sequencer zero store: register access and step walks.
// Assumes the front end model answers each request after lat cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e, raw;
   logic conv_done, conv_req, conv_temp_select, conv_differential, seq_busy, irq, pready, pslverr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r, sel, ctl, m;
   logic [1:0] conv_input_sel;
   logic [3:0] lat = 0;
   int miscompares = 0, n_tests = 0, cyc = 0, seed = 29, n;
   always #2.5 pclk = ~pclk;
   adcs0_seq i_adcs0_seq (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .conv_done, .conv_req, .conv_temp_select, .conv_differential, .conv_input_sel,
      .seq_busy, .irq);
   adcs0_front_model i_adcs0_front_model (.pclk, .presetn, .conv_req, .conv_temp_select, .conv_differential,
      .conv_input_sel, .lat, .conv_done);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s exp %h got %h", s, exp, got);
      end
   endtask
   task automatic conclude();
      $display("mismatches %0d checks %0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One APB transfer; an idle edge follows so the next setup never lands in the same step.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (!pready) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Number of steps walked: up to the first end marker, else all eight.
   function automatic int steps(input logic [31:0] c);
      for (int s = 0; s < 8; s++) if (c[4*s+1]) return s + 1;
      return 8;
   endfunction
   // A hang is cut short well beyond the fewer than two thousand cycles the run needs.
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin
         miscompares++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // A reset value, an unmapped read, field masking, then one walk per end position.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, 12'h044, 0);
      chk("ctl reset", r, 32'h00000000);
      apb(0, 12'h0FC, 0);
      chk("unmapped err", e, 1);
      chk("unmapped data", r, 0);
      for (int i = 0; i < 4; i++) begin
         sel = i ? $random(seed) : 32'hFFFFFFFF;
         apb(1, 12'h040, sel);
         apb(0, 12'h040, 0);
         chk("sel rw", r, sel & 32'h33333333);
      end
      for (int k = 0; k <= 8; k++) begin
         sel = $random(seed);
         ctl = $random(seed) & 32'hDDDDDDDD;
         if (k < 8) ctl[4*k+1] = 1'b1;
         m = $random(seed) & 32'h00000003;
         lat <= k ? 4'($random(seed)) : 4'h0;
         apb(1, 12'h040, sel);
         apb(1, 12'h044, ctl);
         apb(0, 12'h044, 0);
         chk("ctl rw", r, ctl);
         chk("ctl err", e, 0);
         apb(1, 12'h04C, m);
         apb(1, 12'h050, 1);
         repeat (3) @(posedge pclk);
         while (seq_busy) @(posedge pclk);
         n = steps(ctl);
         raw = 1'b0;
         chk("count", i_adcs0_front_model.seen.size(), n);
         for (int s = 0; s < n; s++) begin
            raw |= ctl[4*s+2];
            chk("step", i_adcs0_front_model.seen[s], {ctl[4*s+3], ctl[4*s] & !ctl[4*s+3], sel[4*s +: 2]});
         end
         i_adcs0_front_model.seen.delete();
         apb(0, 12'h054, 0);
         chk("run status", r, 32'(n - 1) << 4);
         apb(0, 12'h048, 0);
         chk("status", r, {30'h0, 1'b1, raw});
         chk("irq", irq, |({1'b1, raw} & m[1:0]));
         apb(1, 12'h048, 3);
         apb(0, 12'h048, 0);
         chk("cleared", {r[1:0], irq}, 0);
      end
      conclude();
   end
endmodule
`default_nettype wire
